// ---- core/def_defines.vh ----
// constants for the downstream error forwarding block
// assumes: included by core/def_downstream_err.v only
`ifndef DEF_DEFINES_VH
`define DEF_DEFINES_VH
// apb register byte offsets
`define DEF_OFF_CTRL 12'h000
`define DEF_OFF_MASK 12'h004
`define DEF_OFF_SEV 12'h008
`define DEF_OFF_STAT 12'h00c
`define DEF_OFF_HDR 12'h010
`define DEF_OFF_SHDR 12'h014
`define DEF_OFF_PTR 12'h018
// control bits
`define DEF_C_SERR 0
`define DEF_C_FTL 1
`define DEF_C_NFTL 2
`define DEF_C_COR 3
`define DEF_C_PARITY_RESPONSE_ENABLE 4
`define DEF_C_SPERESP 5
// mask and severity bits (severity 1 = fatal)
`define DEF_M_ADVISORY_NONFATAL 0
`define DEF_M_POISONED_PACKET_STATUS 1
`define DEF_M_ECRC 2
`define DEF_M_UNCORRECTABLE_DATA_ERROR_STATUS 3
`define DEF_M_PERRAD 4
// status bits (write one to clear)
`define DEF_S_CORD 0
`define DEF_S_NFTLD 1
`define DEF_S_FTLD 2
`define DEF_S_ADVISORY_NONFATAL 3
`define DEF_S_POISONED_PACKET_STATUS 4
`define DEF_S_ECRC 5
`define DEF_S_DPE 6
`define DEF_S_PMDP 7
`define DEF_S_SMDP 8
`define DEF_S_SSERR 9
`define DEF_S_UNCORRECTABLE_DATA_ERROR_STATUS 10
`define DEF_S_PERRAD 11
`define DEF_S_PTRV 12
`define DEF_S_SPTRV 13
// first error pointer codes
`define DEF_PTR_POISONED_PACKET_STATUS 5'h0c
`define DEF_PTR_ECRC 5'h13
`define DEF_PTR_UNCORRECTABLE_DATA_ERROR_STATUS 5'h08
`define DEF_PTR_PERRAD 5'h0b
// completion status codes
`define DEF_CPL_SC 3'h0
`define DEF_CPL_UR 3'h1
`define DEF_CPL_CA 3'h4
// cycles the parity pin is watched after a poisoned write goes out
`define DEF_PERR_WIN 3'h6
// reset values
`define DEF_RST_MASK 5'h00
`define DEF_RST_SEV 5'h06
`endif

// ---- core/def_downstream_err.v ----
// downstream error forwarding, logging and reporting for a pcie-pci bridge
// assumes: all event inputs are one-cycle pulses from logic on CLK_SYS,
// except PARITY_ERROR_PIN_N, which comes from the pci pins.
// Notes on behaviour
// - poisoned write or read completion: invert parity on every forwarded phase
// - request with ecrc error is dropped, never forwarded to pci
// - immediate data error: read gets poisoned success, write gets UR
// - immediate master-abort gives UR, target-abort gives completer abort
// - advisory non-fatal: set correctable-detected and advisory status bits
// - advisory unmasked: set poison status, log header, correctable message
// - advisory masked: no message, still set correctable and advisory bits
// - non-advisory poison: fatal message if enabled, set detected, log
// - fatal poison message with system-error enable sets signaled system error
// - poison sets detected parity; read completion also primary master parity
// - parity pin on poisoned write: secondary bits, log, no message
// - ecrc: drop, set parity and ecrc status, log if unmasked
// - ecrc unmasked: message by severity if enabled, set detected bits
// - immediate read data error: detected parity, secondary parity, drive pin
// - set secondary data error status, log secondary header if unmasked
// - secondary data error unmasked: message by severity, detected bit
// - after read data error keep fetching, then poisoned success completion
// - fatal/nonfatal allowed by serr or own enable; correctable by own
// - detected bits set regardless of reporting enables
`timescale 1ns/100ps
`include "def_defines.vh"

module def_downstream_err (
  input wire CLK_SYS,
  input wire RESETN,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire RX_VALID,
  input wire RX_POISONED,
  input wire RX_ECRC_ERR,
  input wire RX_IS_RDCPL,
  input wire RX_PAR,
  input wire [31:0] RX_HDR,
  output reg FWD_VALID,
  output reg FWD_PAR,
  input wire FWD_WRITE,
  input wire PARITY_ERROR_PIN_N,
  output reg PARITY_ERROR_OUT_N,
  output reg PARITY_ERROR_OE,
  input wire IMM_DONE,
  input wire IMM_READ,
  input wire IMM_DATA_ERR,
  input wire IMM_MABORT,
  input wire IMM_TABORT,
  input wire IMM_LAST,
  input wire [31:0] IMM_HDR,
  output reg CPL_VALID,
  output reg [2:0] CPL_STATUS,
  output reg CPL_POISON,
  output reg MSG_FATAL,
  output reg MSG_NONFATAL,
  output reg MSG_COR
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [5:0] ctrl;
  reg [4:0] mask;
  reg [4:0] sev;
  reg [13:0] stat;
  reg [31:0] hdr_log;
  reg [31:0] shdr_log;
  reg [4:0] first_error_pointer;
  reg [4:0] secondary_first_error_pointer;
  reg perr_s1;
  reg perr_s2;
  reg fwd_poison;
  reg rd_err_seen;
  // logs are read-only; software frees them by clearing the valid bits
  reg [2:0] perr_win;
  reg [31:0] fwd_hdr;
  reg [31:0] perr_hdr;

  wire system_error_enable = ctrl[`DEF_C_SERR];
  wire fatal_report_enable = ctrl[`DEF_C_FTL];
  wire nonfatal_report_enable = ctrl[`DEF_C_NFTL];
  wire correctable_report_enable = ctrl[`DEF_C_COR];
  wire parity_response_enable = ctrl[`DEF_C_PARITY_RESPONSE_ENABLE];
  wire secondary_parity_response_enable = ctrl[`DEF_C_SPERESP];
  wire ptr_valid = stat[`DEF_S_PTRV];
  wire sptr_valid = stat[`DEF_S_SPTRV];

  // message permission for a given severity
  function allow_msg;
    input fatal;
    input serr;
    input ften;
    input nfen;
    begin
      allow_msg = serr | (fatal ? ften : nfen);
    end
  endfunction

  // ----------------------------------------------------------------
  // event classification
  // ----------------------------------------------------------------
  // ecrc wins over poison: a dword with a bad crc is never forwarded,
  // so its poison bit carries no meaning
  wire ecrc_ev = RX_VALID & RX_ECRC_ERR;
  wire poison_ev = RX_VALID & RX_POISONED & ~RX_ECRC_ERR;
  wire poison_adv = poison_ev & ~sev[`DEF_M_POISONED_PACKET_STATUS];
  wire adv_unmasked = poison_adv & ~mask[`DEF_M_ADVISORY_NONFATAL];
  wire poison_ftl = poison_ev & sev[`DEF_M_POISONED_PACKET_STATUS];
  wire ftl_msg_poison = poison_ftl & ~mask[`DEF_M_POISONED_PACKET_STATUS] &
    allow_msg(1'b1, system_error_enable, fatal_report_enable,
    nonfatal_report_enable);
  wire log_poison = (adv_unmasked | poison_ftl) & ~mask[`DEF_M_POISONED_PACKET_STATUS];
  wire ecrc_unm = ecrc_ev & ~mask[`DEF_M_ECRC];
  wire ecrc_msg = ecrc_unm & allow_msg(sev[`DEF_M_ECRC],
    system_error_enable, fatal_report_enable,
    nonfatal_report_enable);
  wire uncorrectable_data_error_status_ev = IMM_DONE & IMM_READ & IMM_DATA_ERR;
  wire uncorrectable_data_error_status_unm = uncorrectable_data_error_status_ev & ~mask[`DEF_M_UNCORRECTABLE_DATA_ERROR_STATUS];
  wire uncorrectable_data_error_status_msg = uncorrectable_data_error_status_unm & allow_msg(sev[`DEF_M_UNCORRECTABLE_DATA_ERROR_STATUS],
    system_error_enable, fatal_report_enable,
    nonfatal_report_enable);
  // target flagged a poisoned write inside the watch window
  wire perr_ev = ~perr_s2 & (perr_win != 3'h0);

  // ----------------------------------------------------------------
  // apb slave, one wait state
  // ----------------------------------------------------------------
  // ready comes from a flop, so every access costs one extra cycle;
  // in return the ready path stays off the bus timing
  wire acc = PSEL & PENABLE & ~PREADY;
  wire wr = acc & PWRITE;
  wire wr_stat = wr & (PADDR == `DEF_OFF_STAT);
  wire [13:0] clr = wr_stat ? PWDATA[13:0] : 14'h0000;
  reg [31:0] rd_mux;
  reg rd_err;

  always @* begin
    rd_err = 1'b0;
    if (PADDR == `DEF_OFF_CTRL) begin
      rd_mux = {26'h0000000, ctrl};
    end else if (PADDR == `DEF_OFF_MASK) begin
      rd_mux = {27'h0000000, mask};
    end else if (PADDR == `DEF_OFF_SEV) begin
      rd_mux = {27'h0000000, sev};
    end else if (PADDR == `DEF_OFF_STAT) begin
      rd_mux = {18'h00000, stat};
    end else if (PADDR == `DEF_OFF_HDR) begin
      rd_mux = hdr_log;
    end else if (PADDR == `DEF_OFF_SHDR) begin
      rd_mux = shdr_log;
    end else if (PADDR == `DEF_OFF_PTR) begin
      rd_mux = {19'h00000, secondary_first_error_pointer, 3'h0,
        first_error_pointer};
    end else begin
      rd_mux = 32'h00000000;
      rd_err = 1'b1;
    end
  end

  always @(posedge CLK_SYS) begin
    if (!RESETN) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
      ctrl <= 6'h00;
      mask <= `DEF_RST_MASK;
      sev <= `DEF_RST_SEV;
    end else begin
      PREADY <= acc;
      PSLVERR <= acc & rd_err;
      PRDATA <= (acc & ~PWRITE) ? rd_mux : 32'h00000000;
      if (wr && PADDR == `DEF_OFF_CTRL) begin
        ctrl <= PWDATA[5:0];
      end
      if (wr && PADDR == `DEF_OFF_MASK) begin
        mask <= PWDATA[4:0];
      end
      if (wr && PADDR == `DEF_OFF_SEV) begin
        sev <= PWDATA[4:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // status, sets win over software clears
  // ----------------------------------------------------------------
  // a set and a clear in one cycle leave the bit set, so no event is
  // lost to a late software clear
  reg [13:0] set;
  always @* begin
    set = 14'h0000;
    set[`DEF_S_CORD] = poison_adv;
    set[`DEF_S_ADVISORY_NONFATAL] = poison_adv;
    set[`DEF_S_POISONED_PACKET_STATUS] = adv_unmasked | poison_ftl;
    set[`DEF_S_FTLD] = poison_ftl | (ecrc_unm & sev[`DEF_M_ECRC]) |
      (uncorrectable_data_error_status_unm & sev[`DEF_M_UNCORRECTABLE_DATA_ERROR_STATUS]);
    set[`DEF_S_NFTLD] = (ecrc_unm & ~sev[`DEF_M_ECRC]) |
      (uncorrectable_data_error_status_unm & ~sev[`DEF_M_UNCORRECTABLE_DATA_ERROR_STATUS]);
    set[`DEF_S_DPE] = poison_ev | ecrc_ev | uncorrectable_data_error_status_ev;
    set[`DEF_S_PMDP] = poison_ev & RX_IS_RDCPL &
      parity_response_enable;
    set[`DEF_S_SMDP] = (perr_ev | uncorrectable_data_error_status_ev) &
      secondary_parity_response_enable;
    set[`DEF_S_ECRC] = ecrc_ev;
    set[`DEF_S_SSERR] = system_error_enable & (ftl_msg_poison | ecrc_msg |
      uncorrectable_data_error_status_msg);
    set[`DEF_S_UNCORRECTABLE_DATA_ERROR_STATUS] = uncorrectable_data_error_status_ev;
    set[`DEF_S_PERRAD] = perr_ev;
    set[`DEF_S_PTRV] = (log_poison | ecrc_unm) & ~ptr_valid;
    set[`DEF_S_SPTRV] = (uncorrectable_data_error_status_unm | (perr_ev & ~mask[`DEF_M_PERRAD])) &
      ~sptr_valid;
  end

  always @(posedge CLK_SYS) begin
    if (!RESETN) begin
      stat <= 14'h0000;
      hdr_log <= 32'h00000000;
      shdr_log <= 32'h00000000;
      first_error_pointer <= 5'h00;
      secondary_first_error_pointer <= 5'h00;
    end else begin
      stat <= (stat & ~clr) | set;
      // log only while no pointer is valid, first error kept
      if (!ptr_valid && ecrc_unm) begin
        hdr_log <= RX_HDR;
        first_error_pointer <= `DEF_PTR_ECRC;
      end else if (!ptr_valid && log_poison) begin
        hdr_log <= RX_HDR;
        first_error_pointer <= `DEF_PTR_POISONED_PACKET_STATUS;
      end
      if (!sptr_valid && uncorrectable_data_error_status_unm) begin
        shdr_log <= IMM_HDR;
        secondary_first_error_pointer <= `DEF_PTR_UNCORRECTABLE_DATA_ERROR_STATUS;
      end else if (!sptr_valid && perr_ev && !mask[`DEF_M_PERRAD]) begin
        shdr_log <= perr_hdr;
        secondary_first_error_pointer <= `DEF_PTR_PERRAD;
      end
    end
  end

  // ----------------------------------------------------------------
  // forwarding path and messages
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS) begin
    if (!RESETN) begin
      perr_s1 <= 1'b1;
      perr_s2 <= 1'b1;
      FWD_VALID <= 1'b0;
      FWD_PAR <= 1'b0;
      fwd_poison <= 1'b0;
      MSG_FATAL <= 1'b0;
      MSG_NONFATAL <= 1'b0;
      MSG_COR <= 1'b0;
    end else begin
      perr_s1 <= PARITY_ERROR_PIN_N;
      perr_s2 <= perr_s1;
      // one stage only: the dword leaves a cycle after it arrives, and
      // any stall must be handled by the sender
      FWD_VALID <= RX_VALID & ~RX_ECRC_ERR;
      FWD_PAR <= RX_PAR ^ (RX_POISONED & ~RX_ECRC_ERR);
      fwd_poison <= RX_VALID & RX_POISONED & ~RX_ECRC_ERR;
      // the pin result never raises a message here
      MSG_COR <= adv_unmasked & correctable_report_enable;
      MSG_FATAL <= ftl_msg_poison | (ecrc_msg & sev[`DEF_M_ECRC]) |
        (uncorrectable_data_error_status_msg & sev[`DEF_M_UNCORRECTABLE_DATA_ERROR_STATUS]);
      MSG_NONFATAL <= (ecrc_msg & ~sev[`DEF_M_ECRC]) |
        (uncorrectable_data_error_status_msg & ~sev[`DEF_M_UNCORRECTABLE_DATA_ERROR_STATUS]);
    end
  end

  // ----------------------------------------------------------------
  // parity-pin watch window
  // ----------------------------------------------------------------
  // the target answers a data phase some cycles later and the pin then
  // crosses two sync flops, so the window must outlast both delays
  wire perr_open = fwd_poison & FWD_WRITE;

  always @(posedge CLK_SYS) begin
    if (!RESETN) begin
      perr_win <= 3'h0;
      fwd_hdr <= 32'h00000000;
      perr_hdr <= 32'h00000000;
    end else begin
      if (poison_ev) begin
        fwd_hdr <= RX_HDR;
      end
      if (perr_open) begin
        perr_win <= `DEF_PERR_WIN;
        perr_hdr <= fwd_hdr;
      end else if (perr_win != 3'h0) begin
        perr_win <= perr_win - 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // immediate completions
  // ----------------------------------------------------------------
  // only the last phase or an abort closes a completion; error phases
  // before it are folded in through rd_err_seen
  always @(posedge CLK_SYS) begin
    if (!RESETN) begin
      rd_err_seen <= 1'b0;
      CPL_VALID <= 1'b0;
      CPL_STATUS <= `DEF_CPL_SC;
      CPL_POISON <= 1'b0;
      PARITY_ERROR_OUT_N <= 1'b1;
      PARITY_ERROR_OE <= 1'b0;
    end else begin
      PARITY_ERROR_OUT_N <= ~(uncorrectable_data_error_status_ev & secondary_parity_response_enable);
      PARITY_ERROR_OE <= uncorrectable_data_error_status_ev & secondary_parity_response_enable;
      CPL_VALID <= 1'b0;
      if (IMM_DONE) begin
        // the read goes on fetching; error remembered to the last phase
        if (IMM_LAST) begin
          rd_err_seen <= 1'b0;
        end else if (uncorrectable_data_error_status_ev) begin
          rd_err_seen <= 1'b1;
        end
      end
      if (IMM_DONE && (IMM_LAST || IMM_MABORT || IMM_TABORT)) begin
        CPL_VALID <= 1'b1;
        CPL_POISON <= 1'b0;
        if (IMM_MABORT) begin
          CPL_STATUS <= `DEF_CPL_UR;
        end else if (IMM_TABORT) begin
          CPL_STATUS <= `DEF_CPL_CA;
        end else if (IMM_DATA_ERR && !IMM_READ) begin
          CPL_STATUS <= `DEF_CPL_UR;
        end else begin
          CPL_STATUS <= `DEF_CPL_SC;
          CPL_POISON <= IMM_READ & (IMM_DATA_ERR | rd_err_seen);
        end
      end
    end
  end

endmodule

// ---- verification/def_pci_target.sv ----
// pci target model: flags bad parity on the parity error pin
// assumes: one bridge clock; the pin has a pull-up
`timescale 1ns/100ps
module def_pci_target (
  input wire clk,
  input wire fwd_valid,
  input wire perr_en,
  input wire drv_oe,
  input wire drv_n,
  output wire pin_n
);
  reg [2:0] sr = 3'h0;
  always @(posedge clk) begin
    sr <= {sr[1:0], fwd_valid & perr_en};
  end
  // pulled high unless the target or the bridge pulls it down
  assign pin_n = !(sr[1] | sr[2]) && !(drv_oe && !drv_n);
endmodule

// ---- verification/def_downstream_err_props.sv ----
// port checker for the downstream error block
// assumes: bound to def_downstream_err, single clock domain
`timescale 1ns/100ps
module def_downstream_err_props (
  input wire CLK_SYS,
  input wire RESETN,
  input wire PSEL,
  input wire PENABLE,
  input wire PREADY,
  input wire PSLVERR,
  input wire RX_VALID,
  input wire RX_POISONED,
  input wire RX_ECRC_ERR,
  input wire RX_PAR,
  input wire FWD_VALID,
  input wire FWD_PAR,
  input wire IMM_DONE,
  input wire IMM_MABORT,
  input wire IMM_TABORT,
  input wire CPL_VALID,
  input wire [2:0] CPL_STATUS,
  input wire PARITY_ERROR_OUT_N,
  input wire PARITY_ERROR_OE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  fwd_drop_a: assert property (
    RX_VALID && RX_ECRC_ERR |=> !FWD_VALID) else $error("ecrc forwarded");
  fwd_pass_a: assert property (
    RX_VALID && !RX_ECRC_ERR |=> FWD_VALID) else $error("dword lost");
  par_flip_a: assert property (
    RX_VALID && !RX_ECRC_ERR |=>
      FWD_PAR == ($past(RX_PAR) ^ $past(RX_POISONED)))
    else $error("forwarded parity wrong");
  mabort_ur_a: assert property (
    IMM_DONE && IMM_MABORT |=> CPL_VALID && CPL_STATUS == 3'h1)
    else $error("master abort not UR");
  tabort_ca_a: assert property (
    IMM_DONE && IMM_TABORT |=> CPL_VALID && CPL_STATUS == 3'h4)
    else $error("target abort not CA");
  cpl_cause_a: assert property (
    CPL_VALID |-> $past(IMM_DONE)) else $error("completion without cause");
  pin_low_a: assert property (
    PARITY_ERROR_OE |-> !PARITY_ERROR_OUT_N) else $error("pin driven high");
  pin_cause_a: assert property (
    PARITY_ERROR_OE |-> $past(IMM_DONE)) else $error("pin drive uncaused");
  apb_wait_a: assert property (
    PSEL && PENABLE && !PREADY |=> PREADY) else $error("apb answer late");
  apb_err_a: assert property (
    PSLVERR |-> PREADY) else $error("slave error without ready");
  cover property (RX_VALID && RX_ECRC_ERR);
  cover property (IMM_DONE && IMM_MABORT);
  cover property (PARITY_ERROR_OE);
endmodule
bind def_downstream_err def_downstream_err_props def_downstream_err_props_inst (
  .CLK_SYS(CLK_SYS), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .RX_VALID(RX_VALID),
  .RX_POISONED(RX_POISONED), .RX_ECRC_ERR(RX_ECRC_ERR), .RX_PAR(RX_PAR),
  .FWD_VALID(FWD_VALID), .FWD_PAR(FWD_PAR), .IMM_DONE(IMM_DONE),
  .IMM_MABORT(IMM_MABORT), .IMM_TABORT(IMM_TABORT), .CPL_VALID(CPL_VALID),
  .CPL_STATUS(CPL_STATUS), .PARITY_ERROR_OUT_N(PARITY_ERROR_OUT_N),
  .PARITY_ERROR_OE(PARITY_ERROR_OE));

// ---- verification/def_downstream_err_tb.sv ----
// self-checking bench for the downstream error block
// assumes: apb answers after a two-cycle access; status is write-one-clear
`timescale 1ns/100ps
module def_downstream_err_tb;
  reg CLK_SYS = 1'h0, RESETN = 1'h0, PSEL = 1'h0, PENABLE = 1'h0;
  reg PWRITE = 1'h0, RX_VALID = 1'h0, RX_POISONED = 1'h0, RX_ECRC_ERR = 1'h0;
  reg RX_IS_RDCPL = 1'h0, RX_PAR = 1'h0, FWD_WRITE = 1'h0, IMM_DONE = 1'h0;
  reg IMM_READ = 1'h0, IMM_DATA_ERR = 1'h0, IMM_MABORT = 1'h0;
  reg IMM_TABORT = 1'h0, IMM_LAST = 1'h0, perr_en = 1'h0, se, clr_mc = 1'h0;
  reg [11:0] PADDR = 12'h0;
  reg [31:0] PWDATA = 32'h0, RX_HDR = 32'h0, IMM_HDR = 32'h0, q, hh;
  wire [31:0] PRDATA;
  wire [2:0] CPL_STATUS;
  wire PREADY, PSLVERR, FWD_VALID, FWD_PAR, PARITY_ERROR_PIN_N, CPL_VALID;
  wire PARITY_ERROR_OUT_N, PARITY_ERROR_OE, CPL_POISON;
  wire MSG_FATAL, MSG_NONFATAL, MSG_COR;
  reg [5:0] c;
  reg [4:0] m, s;
  reg [2:0] mc = 3'h0;
  reg [16:0] x;
  integer num_errors = 0, n_checks = 0, i;
  always #5 CLK_SYS = !CLK_SYS;
  // messages are pulses: gather them over a whole scenario
  always @(posedge CLK_SYS)
    mc <= (clr_mc ? 3'h0 : mc) | {MSG_FATAL, MSG_NONFATAL, MSG_COR};
  def_downstream_err def_downstream_err_inst (.CLK_SYS(CLK_SYS),
    .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .RX_VALID(RX_VALID), .RX_POISONED(RX_POISONED),
    .RX_ECRC_ERR(RX_ECRC_ERR), .RX_IS_RDCPL(RX_IS_RDCPL), .RX_PAR(RX_PAR),
    .RX_HDR(RX_HDR), .FWD_VALID(FWD_VALID), .FWD_PAR(FWD_PAR),
    .FWD_WRITE(FWD_WRITE), .PARITY_ERROR_PIN_N(PARITY_ERROR_PIN_N),
    .PARITY_ERROR_OUT_N(PARITY_ERROR_OUT_N),
    .PARITY_ERROR_OE(PARITY_ERROR_OE), .IMM_DONE(IMM_DONE),
    .IMM_READ(IMM_READ), .IMM_DATA_ERR(IMM_DATA_ERR),
    .IMM_MABORT(IMM_MABORT), .IMM_TABORT(IMM_TABORT), .IMM_LAST(IMM_LAST),
    .IMM_HDR(IMM_HDR), .CPL_VALID(CPL_VALID), .CPL_STATUS(CPL_STATUS),
    .CPL_POISON(CPL_POISON), .MSG_FATAL(MSG_FATAL),
    .MSG_NONFATAL(MSG_NONFATAL), .MSG_COR(MSG_COR));
  def_pci_target def_pci_target_inst (.clk(CLK_SYS), .fwd_valid(FWD_VALID),
    .perr_en(perr_en), .drv_oe(PARITY_ERROR_OE),
    .drv_n(PARITY_ERROR_OUT_N), .pin_n(PARITY_ERROR_PIN_N));
  task chk(input [31:0] a, input [31:0] b);
    begin
      n_checks = n_checks + 1;
      if (a !== b) begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: got %h want %h", $time, a, b);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer t;
    begin
      t = 0;
      @(posedge CLK_SYS);
      PSEL <= 1'h1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK_SYS);
      PENABLE <= 1'h1;
      @(posedge CLK_SYS);
      while (PREADY !== 1'h1 && t < 50) begin
        @(posedge CLK_SYS);
        t = t + 1;
      end
      if (PREADY !== 1'h1) num_errors = num_errors + 1;
      q = PRDATA;
      se = PSLVERR;
      PSEL <= 1'h0;
      PENABLE <= 1'h0;
    end
  endtask
  // reference model: expected {fatal, nonfatal, cor, status}
  function [16:0] exp(input p, input e, input r, input u, input pe);
    reg [13:0] t;
    reg f, n, k, sv, um;
    begin
      t = 14'h0;
      f = 1'h0;
      n = 1'h0;
      k = 1'h0;
      sv = e ? s[2] : s[3];
      um = e ? !m[2] : !m[3];
      if (e | u) begin
        t[6] = 1'h1;
        t[5] = e;
        t[12] = e & um;
        t[10] = u;
        t[13] = u & um;
        t[8] = u & c[5];
        f = um & sv & (c[0] | c[1]);
        n = um & !sv & (c[0] | c[2]);
        t[2] = um & sv;
        t[1] = um & !sv;
      end else if (p) begin
        t[6] = 1'h1;
        t[7] = r & c[4];
        if (!s[1]) begin
          t[0] = 1'h1;
          t[3] = 1'h1;
          t[4] = !m[0];
          t[12] = !m[0] & !m[1];
          k = !m[0] & c[3];
        end else begin
          t[2] = 1'h1;
          t[4] = 1'h1;
          t[12] = !m[1];
          f = !m[1] & (c[0] | c[1]);
        end
      end
      if (pe) begin
        t[11] = 1'h1;
        t[8] = c[5];
        t[13] = 1'h1;
      end
      t[9] = (f | n) & c[0];
      exp = {f, n, k, t};
    end
  endfunction
  task result(input [11:0] ha, input [31:0] h, input lg);
    begin
      @(posedge CLK_SYS);
      clr_mc <= 1'h0;
      repeat (5) @(posedge CLK_SYS);
      chk(mc, x[16:14]);
      apb(1'h0, 12'h00c, 32'h0);
      chk(q[13:0], x[13:0]);
      if (lg) begin
        apb(1'h0, ha, 32'h0);
        chk(q, h);
      end
    end
  endtask
  task rx(input p, input e, input r, input [31:0] h, input [31:0] eh);
    reg pa;
    begin
      pa = $urandom;
      x = exp(p, e, r, 1'h0, p & !r & !e);
      @(posedge CLK_SYS);
      perr_en <= p & !r & !e;
      RX_VALID <= 1'h1;
      RX_POISONED <= p;
      RX_ECRC_ERR <= e;
      RX_IS_RDCPL <= r;
      RX_PAR <= pa;
      RX_HDR <= h;
      FWD_WRITE <= !r;
      @(posedge CLK_SYS);
      RX_VALID <= 1'h0;
      #1;
      clr_mc <= 1'h1;
      chk(FWD_VALID, !e);
      if (!e) chk(FWD_PAR, pa ^ p);
      result(12'h010, eh, x[12]);
      if (p & !r & !e) begin
        apb(1'h0, 12'h014, 32'h0);
        chk(q, h);
      end
    end
  endtask
  task imm(input [4:0] v);
    begin
      @(posedge CLK_SYS);
      IMM_DONE <= 1'h1;
      clr_mc <= 1'h0;
      {IMM_READ, IMM_DATA_ERR, IMM_MABORT, IMM_TABORT, IMM_LAST} <= v;
      if (v[3]) IMM_HDR <= $urandom;
      @(posedge CLK_SYS);
      IMM_DONE <= 1'h0;
      #1;
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    #200000;
    num_errors = num_errors + 1;
    print_verdict;
  end
  initial begin
    hh = $urandom(27974);
    repeat (20) @(posedge CLK_SYS);
    RESETN <= 1'h1;
    apb(1'h0, 12'h008, 32'h0);
    chk(q, 32'h6);
    apb(1'h0, 12'h100, 32'h0);
    chk(se, 1'h1);
    chk(q, 32'h0);
    for (i = 0; i < 24; i = i + 1) begin
      c = $urandom;
      m = $urandom & 5'h0f;
      s = $urandom;
      hh = $urandom;
      apb(1'h1, 12'h000, c);
      apb(1'h1, 12'h004, m);
      apb(1'h1, 12'h008, s);
      case (i % 4)
        0: rx(1'h1, 1'h0, 1'h0, hh, hh);
        1: rx(1'h1, 1'h0, 1'h1, hh, hh);
        2: rx(i[3], 1'h1, 1'h0, hh, hh);
        default: begin
          x = exp(1'h0, 1'h0, 1'h0, 1'h1, 1'h0);
          imm(5'h18);
          clr_mc <= 1'h1;
          chk({PARITY_ERROR_OE, PARITY_ERROR_OUT_N}, {c[5], !c[5]});
          imm(5'h11);
          chk({CPL_VALID, CPL_STATUS, CPL_POISON}, 5'h11);
          result(12'h014, IMM_HDR, x[13]);
        end
      endcase
      apb(1'h1, 12'h00c, 32'h3fff);
    end
    m = 5'h00;
    s = 5'h06;
    apb(1'h1, 12'h004, m);
    apb(1'h1, 12'h008, s);
    rx(1'h1, 1'h0, 1'h1, 32'h1, 32'h1);
    rx(1'h1, 1'h0, 1'h1, 32'h2, 32'h1);
    for (i = 0; i < 3; i = i + 1) begin
      imm(15'h24b3 >> (10 - 5 * i));
      chk({CPL_VALID, CPL_STATUS, CPL_POISON},
          (15'h4a58 >> (10 - 5 * i)) & 5'h1f);
    end
    print_verdict;
  end
endmodule
